//--- inc/hsc_pkg.sv
// shared constants and types for the hardware strap configuration decoder
package hsc_pkg;
    localparam int NUM_CH = 2;

    // flip-flop stages every strap bit passes before it is trusted
    localparam int SYNC_STAGES = 3;

    // transmit pattern select codes
    localparam logic [1:0] PAT_NORMAL    = 2'h0;
    localparam logic [1:0] PAT_ALL_ONES  = 2'h1;
    localparam logic [1:0] PAT_PRBS      = 2'h2;
    localparam logic [1:0] PAT_POWERDOWN = 2'h3;

    // loopback select codes
    localparam logic [1:0] LOOP_NONE    = 2'h0;
    localparam logic [1:0] LOOP_ANALOG  = 2'h1;
    localparam logic [1:0] LOOP_DIGITAL = 2'h2;
    localparam logic [1:0] LOOP_REMOTE  = 2'h3;

    // jitter attenuator select codes
    localparam logic [1:0] JA_OFF       = 2'h0;
    localparam logic [1:0] JA_RX_BROAD  = 2'h1;
    localparam logic [1:0] JA_RX_NARROW = 2'h2;
    localparam logic [1:0] JA_TX_NARROW = 2'h3;

    // jitter attenuator fifo depths in bits
    localparam logic [7:0] JA_DEPTH_SHORT = 8'h40;
    localparam logic [7:0] JA_DEPTH_LONG  = 8'h80;
    localparam logic [7:0] JA_DEPTH_NONE  = 8'h00;

    // monitor gain in dB
    localparam logic [4:0] MON_GAIN_LOW  = 5'h00;
    localparam logic [4:0] MON_GAIN_HIGH = 5'h1a;

    // debounce agreement state encodings, one-hot
    typedef enum logic [1:0] {
        SYNC_FILL = 2'b01,
        SYNC_RUN  = 2'b10
    } hsc_sync_state_t;
endpackage : hsc_pkg

//--- inc/hsc_strap_if.sv
// carrier for raw and synchronised strap bits between decoder modules
`timescale 1ns/1ps
`default_nettype none
interface hsc_strap_if #(parameter int W = 14);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    logic         valid;
    modport sync_side (input raw, output clean, output valid);
    modport user_side (output raw, input clean, input valid);
endinterface : hsc_strap_if
`default_nettype wire

//--- design/hsc_strap_sync.sv
// three-stage strap synchroniser with second/third stage agreement
`timescale 1ns/1ps
`default_nettype none
module hsc_strap_sync
    import hsc_pkg::*;
#(
    parameter int W = 14
)(
    // clock and reset
    input wire logic    clk,
    input wire logic    reset_n,
    // strap bits
    hsc_strap_if.sync_side s
);
    logic [W-1:0]    meta_q;
    logic [W-1:0]    s2_q;
    logic [W-1:0]    s3_q;
    logic [W-1:0]    clean_q;
    logic [SYNC_STAGES-1:0] fill_q;
    hsc_sync_state_t st_q;
    hsc_sync_state_t st_d;
    wire  [W-1:0]    agree    = ~(s2_q ^ s3_q);
    wire             filled   = fill_q[SYNC_STAGES-1];
    wire             run_w    = (st_q == SYNC_RUN);
    // stage three holds real pin levels only once the pipe has filled;
    // valid earlier would decode reset zeros and pulse the drivers on
    wire             load_all = (st_q == SYNC_FILL) && filled;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            SYNC_FILL:
                if (filled)
                    st_d = SYNC_RUN;
            SYNC_RUN:
                st_d = SYNC_RUN;
            default:
                st_d = SYNC_FILL;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            meta_q <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            fill_q <= '0;
            st_q   <= SYNC_FILL;
        end
        else
        begin
            meta_q <= s.raw;
            s2_q   <= meta_q;
            s3_q   <= s2_q;
            fill_q <= {fill_q[SYNC_STAGES-2:0], 1'b1};
            st_q   <= st_d;
        end
    end

    // after the one-cycle fill load, each bit updates only when stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk)
            begin
                if (!reset_n)
                    clean_q[i] <= 1'b0;
                else if (load_all || (run_w && agree[i]))
                    clean_q[i] <= s3_q[i];
            end

            a_clean_hold: assert property (@(posedge clk) disable iff (!reset_n)
                run_w && !agree[i] |=> $stable(clean_q[i]))
                else $error("strap bit moved while sync stages disagreed");
        end
    endgenerate

    assign s.clean = clean_q;
    assign s.valid = (st_q == SYNC_RUN);
endmodule // hsc_strap_sync
`default_nettype wire

//--- design/hsc_strap_decoder.sv
// hardware control mode strap decoder for a two-channel line interface
`timescale 1ns/1ps
`default_nettype none
module hsc_strap_decoder
    import hsc_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // strap pins
    input  wire logic [3:0]   tx_pattern_sel,
    input  wire logic [3:0]   loopback_sel,
    input  wire logic [1:0]   rx_monitor_gain_sel,
    input  wire logic [1:0]   jitter_atten_sel,
    input  wire logic         driver_hiz_ctl,
    input  wire logic         rx_clock_edge_sel,
    // per channel transmit controls
    output var  logic [1:0]   tx_send_all_ones,
    output var  logic [1:0]   tx_send_prbs,
    output var  logic [1:0]   tx_power_down,
    output var  logic [1:0]   tx_driver_oe,
    // per channel loopback and receive controls
    output var  logic [1:0]   loop_analog,
    output var  logic [1:0]   loop_digital,
    output var  logic [1:0]   loop_remote,
    output var  logic [1:0]   inband_loop_enable,
    output var  logic [9:0]   rx_monitor_gain_db,
    // global controls
    output var  logic         ja_enable,
    output var  logic         ja_in_tx_path,
    output var  logic         ja_narrow_bw,
    output var  logic [7:0]   ja_fifo_depth,
    output var  logic         rx_clock_falling,
    output var  logic         config_valid
);
    localparam int W = 14;

    hsc_strap_if #(.W(W)) sif ();

    assign sif.raw = {rx_clock_edge_sel, driver_hiz_ctl, jitter_atten_sel,
                      rx_monitor_gain_sel, loopback_sel, tx_pattern_sel};

    hsc_strap_sync #(.W(W)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .s       (sif.sync_side)
    );

    // synchronised fields
    wire [3:0] pat_s  = sif.clean[3:0];
    wire [3:0] loop_s = sif.clean[7:4];
    wire [1:0] mon_s  = sif.clean[9:8];
    wire [1:0] ja_s   = sif.clean[11:10];
    wire       hiz_s  = sif.clean[12];
    wire       edge_s = sif.clean[13];
    wire       ok_s   = sif.valid;

    // per channel decode
    logic [1:0] ones_d;
    logic [1:0] prbs_d;
    logic [1:0] pd_d;
    logic [1:0] oe_d;
    logic [1:0] la_d;
    logic [1:0] ld_d;
    logic [1:0] lr_d;
    logic [9:0] gain_d;

    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++)
        begin : g_ch
            wire [1:0] p = pat_s[2*c +: 2];
            wire [1:0] l = loop_s[2*c +: 2];
            assign ones_d[c] = ok_s && (p == PAT_ALL_ONES);
            assign prbs_d[c] = ok_s && (p == PAT_PRBS);
            assign pd_d[c]   = ok_s && (p == PAT_POWERDOWN);
            // powered-down channel or global hiz drops the driver
            assign oe_d[c]   = ok_s && !hiz_s && (p != PAT_POWERDOWN);
            assign la_d[c]   = ok_s && (l == LOOP_ANALOG);
            assign ld_d[c]   = ok_s && (l == LOOP_DIGITAL);
            assign lr_d[c]   = ok_s && (l == LOOP_REMOTE);
            assign gain_d[5*c +: 5] = mon_s[c] ? MON_GAIN_HIGH : MON_GAIN_LOW;
        end
    endgenerate

    // global decode
    wire       ja_en_d  = ok_s && (ja_s != JA_OFF);
    wire       ja_tx_d  = ok_s && (ja_s == JA_TX_NARROW);
    wire       ja_nar_d = ok_s && (ja_s == JA_RX_NARROW || ja_s == JA_TX_NARROW);
    wire [7:0] depth_d  = !ja_en_d             ? JA_DEPTH_NONE  :
                          (ja_s == JA_RX_BROAD) ? JA_DEPTH_SHORT :
                                                  JA_DEPTH_LONG;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            tx_send_all_ones   <= '0;
            tx_send_prbs       <= '0;
            tx_power_down      <= '0;
            tx_driver_oe       <= '0;
            loop_analog        <= '0;
            loop_digital       <= '0;
            loop_remote        <= '0;
            inband_loop_enable <= '0;
            rx_monitor_gain_db <= '0;
            ja_enable          <= 1'b0;
            ja_in_tx_path      <= 1'b0;
            ja_narrow_bw       <= 1'b0;
            ja_fifo_depth      <= JA_DEPTH_NONE;
            rx_clock_falling   <= 1'b0;
            config_valid       <= 1'b0;
        end
        else
        begin
            tx_send_all_ones   <= ones_d;
            tx_send_prbs       <= prbs_d;
            tx_power_down      <= pd_d;
            tx_driver_oe       <= oe_d;
            loop_analog        <= la_d;
            loop_digital       <= ld_d;
            loop_remote        <= lr_d;
            // in-band loopback is never offered in strap mode
            inband_loop_enable <= '0;
            rx_monitor_gain_db <= gain_d;
            ja_enable          <= ja_en_d;
            ja_in_tx_path      <= ja_tx_d;
            ja_narrow_bw       <= ja_nar_d;
            ja_fifo_depth      <= depth_d;
            rx_clock_falling   <= ok_s && edge_s;
            config_valid       <= ok_s;
        end
    end

    // assertions
    a_pd_kills_driver: assert property (@(posedge clk) disable iff (!reset_n)
        tx_power_down[0] |-> !tx_driver_oe[0])
        else $error("powered down channel 0 still drives");
    a_hiz_both_off: assert property (@(posedge clk) disable iff (!reset_n)
        $past(hiz_s) && $past(ok_s) |-> tx_driver_oe == 2'b00)
        else $error("hiz did not disable both drivers");
    a_pattern_onehot: assert property (@(posedge clk) disable iff (!reset_n)
        $onehot0({tx_send_all_ones[1], tx_send_prbs[1], tx_power_down[1]}))
        else $error("channel 1 pattern outputs not exclusive");
    a_prbs_decode: assert property (@(posedge clk) disable iff (!reset_n)
        ok_s && pat_s[1:0] == PAT_PRBS |=> tx_send_prbs[0])
        else $error("prbs not selected on channel 0");
    a_ja_short_fifo: assert property (@(posedge clk) disable iff (!reset_n)
        ok_s && ja_s == JA_RX_BROAD |=> ja_fifo_depth == JA_DEPTH_SHORT && !ja_narrow_bw)
        else $error("broad attenuator setting wrong");
    a_ja_tx_path: assert property (@(posedge clk) disable iff (!reset_n)
        ja_in_tx_path |-> ja_enable && ja_narrow_bw && ja_fifo_depth == JA_DEPTH_LONG)
        else $error("transmit attenuator setting wrong");
    a_ja_off: assert property (@(posedge clk) disable iff (!reset_n)
        !ja_enable |-> ja_fifo_depth == JA_DEPTH_NONE)
        else $error("bypassed attenuator has depth");
    a_gain_select: assert property (@(posedge clk) disable iff (!reset_n)
        mon_s[1] |=> rx_monitor_gain_db[9:5] == MON_GAIN_HIGH)
        else $error("channel 1 monitor gain wrong");
    a_loop_remote: assert property (@(posedge clk) disable iff (!reset_n)
        ok_s && loop_s[3:2] == LOOP_REMOTE |=> loop_remote[1] && !loop_analog[1])
        else $error("channel 1 remote loopback wrong");
    a_no_inband: assert property (@(posedge clk) disable iff (!reset_n)
        inband_loop_enable == 2'b00)
        else $error("in-band loopback offered");
    a_edge_select: assert property (@(posedge clk) disable iff (!reset_n)
        ok_s && !edge_s |=> !rx_clock_falling)
        else $error("rising edge not selected");
    a_normal_data: assert property (@(posedge clk) disable iff (!reset_n)
        ok_s && pat_s[3:2] == PAT_NORMAL |=> !tx_send_all_ones[1] && !tx_send_prbs[1])
        else $error("channel 1 normal data disturbed");
endmodule // hsc_strap_decoder
`default_nettype wire

//--- sim/hsc_strap_board.sv
// board strap model driving static levels onto the decoder strap pins
`timescale 1ns/1ps
`default_nettype none
module hsc_strap_board (
    // bench side
    input  wire logic        clk,
    input  wire logic [13:0] want,
    // strap pins
    output var  logic [13:0] pins
);
    // straps are plain levels; they move a little after an edge, never on it
    initial pins = 14'h0;
    always @(posedge clk) pins <= #2 want;
endmodule // hsc_strap_board
`default_nettype wire

//--- sim/hsc_strap_decoder_tb.sv
// self-checking bench for the strap decoder against an integer model
`timescale 1ns/1ps
`default_nettype none
module hsc_strap_decoder_tb;
    logic        clk;
    logic        reset_n;
    logic [13:0] want;
    logic [13:0] pins;
    logic [1:0]  all1, prbs, pdn, oe, lpa, lpd, lpr, inb;
    logic [9:0]  gain;
    logic        ja_en, ja_tx, ja_nb, falling, valid;
    logic [7:0]  depth;
    int          n_fail;
    int          checked;
    int          cyc;
    int          q[$];

    hsc_strap_board hsc_strap_board_i (.clk(clk), .want(want), .pins(pins));

    hsc_strap_decoder hsc_strap_decoder_i (
        .clk(clk), .reset_n(reset_n),
        .tx_pattern_sel(pins[3:0]), .loopback_sel(pins[7:4]),
        .rx_monitor_gain_sel(pins[9:8]), .jitter_atten_sel(pins[11:10]),
        .driver_hiz_ctl(pins[12]), .rx_clock_edge_sel(pins[13]),
        .tx_send_all_ones(all1), .tx_send_prbs(prbs), .tx_power_down(pdn),
        .tx_driver_oe(oe), .loop_analog(lpa), .loop_digital(lpd),
        .loop_remote(lpr), .inband_loop_enable(inb), .rx_monitor_gain_db(gain),
        .ja_enable(ja_en), .ja_in_tx_path(ja_tx), .ja_narrow_bw(ja_nb),
        .ja_fifo_depth(depth), .rx_clock_falling(falling), .config_valid(valid)
    );

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // model of the decoded configuration for strap word s
    task automatic expect_cfg(input int s);
        int          c, p, l, ja;
        logic [15:0] tx, en, lp, gn;
        tx = 0;
        en = 0;
        lp = 0;
        gn = 0;
        ja = (s >> 10) & 3;
        for (c = 0; c < 2; c++)
        begin
            p = (s >> (2 * c)) & 3;
            l = (s >> (4 + 2 * c)) & 3;
            tx[4 + c] = (p == 1);
            tx[2 + c] = (p == 2);
            tx[c] = (p == 3);
            en[c] = (p != 3) && (((s >> 12) & 1) == 0);
            lp[4 + c] = (l == 1);
            lp[2 + c] = (l == 2);
            lp[c] = (l == 3);
            gn[5 * c +: 5] = (((s >> (8 + c)) & 1) != 0) ? 5'h1a : 5'h00;
        end
        chk({all1, prbs, pdn}, tx);
        chk(oe, en);
        chk({lpa, lpd, lpr}, lp);
        chk(inb, 16'h0);
        chk(gain, gn);
        chk({ja_en, ja_tx, ja_nb}, {ja != 0, ja == 3, ja >= 2});
        chk(depth, (ja == 0) ? 16'h0 : (ja == 1) ? 16'h40 : 16'h80);
        chk(falling, 16'((s >> 13) & 1));
        chk(valid, 16'h1);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    initial
    begin
        int s, prev, i;
        reset_n = 1'b0;
        want = 14'h0;
        n_fail = 0;
        checked = 0;
        cyc = 0;
        s = $urandom(32'ha793);
        step(4);
        reset_n = 1'b1;
        chk(valid, 16'h0);
        step(8);
        expect_cfg(0);
        for (i = 0; i < 16; i++)
            q.push_back(i | ((15 - i) << 4) | ((i & 3) << 8) | ((i & 3) << 10) | ((i >> 2) << 12));
        for (i = 0; i < 48; i++)
            q.push_back($urandom & 32'h3fff);
        prev = 0;
        while (q.size() > 0)
        begin
            s = q.pop_front();
            want = s[13:0];
            step(3);
            expect_cfg(prev);
            step(7);
            expect_cfg(s);
            prev = s;
        end
        reset_n = 1'b0;
        step(2);
        chk({all1, prbs, pdn, oe, lpa, lpd, lpr, inb}, 16'h0);
        chk({gain, ja_en, ja_tx, ja_nb, falling, valid}, 16'h0);
        chk(depth, 16'h0);
        reset_n = 1'b1;
        step(1);
        chk(valid, 16'h0);
        step(8);
        expect_cfg(prev);
        print_verdict();
    end
endmodule // hsc_strap_decoder_tb
`default_nettype wire
